// ### core/wake_pkg.sv
package wake_pkg;

    // -------------------------------------------------------------
    // Register byte addresses
    // -------------------------------------------------------------
    localparam logic [7:0] ADDR_PORT_A      = 8'h00;
    localparam logic [7:0] ADDR_KEYPAD_SC   = 8'h04;
    localparam logic [7:0] ADDR_KEYPAD_IE   = 8'h08;
    localparam logic [7:0] ADDR_CONFIG_ONE  = 8'h0c;
    localparam logic [7:0] ADDR_IRQ_STATUS  = 8'h10;
    localparam logic [7:0] ADDR_IRQ_MASK    = 8'h14;

    // -------------------------------------------------------------
    // Field positions
    // -------------------------------------------------------------
    localparam int BIT_WAKE_LATCH     = 6;  // Port A data
    localparam int BIT_PENDING_FLAG   = 3;  // Keypad status/control
    localparam int BIT_ACKNOWLEDGE    = 2;
    localparam int BIT_IRQ_MASK       = 1;
    localparam int BIT_TRIGGER_MODE   = 0;
    localparam int BIT_WAKE_IRQ_EN    = 6;  // Keypad irq enable
    localparam int KEYPAD_PIN_BITS    = 6;  // Pin enables 5..0
    localparam int BIT_RATE_SELECT    = 0;  // Config one
    localparam int BIT_EVT_WAKE       = 0;  // Interrupt status/mask
    localparam int BIT_EVT_KEYPAD     = 1;
    localparam int EVT_BITS           = 2;

    // -------------------------------------------------------------
    // Wakeup counter
    // -------------------------------------------------------------
    localparam int          WAKE_CNT_W         = 14;
    localparam int          WAKE_SHORT_CYCLES  = 2 ** 9;
    localparam int          WAKE_LONG_CYCLES   = 2 ** 14;
    localparam logic [13:0] WAKE_SHORT_LAST    = 14'(WAKE_SHORT_CYCLES - 1);
    localparam logic [13:0] WAKE_LONG_LAST     = 14'(WAKE_LONG_CYCLES - 1);
    localparam logic [13:0] WAKE_CNT_ZERO      = 14'h0000;
    localparam logic [13:0] WAKE_CNT_ONE       = 14'h0001;

    // -------------------------------------------------------------
    // Reset values
    // -------------------------------------------------------------
    localparam logic [31:0] DATA_ZERO          = 32'h0000_0000;
    localparam logic [5:0]  PIN_EN_RESET       = 6'h00;
    localparam logic [1:0]  EVT_RESET          = 2'h0;

endpackage

// ### core/auto_wake_unit.sv
`timescale 1ns/1ps
module auto_wake_unit (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr,
    input  wire logic        stop_mode,
    input  wire logic        internal_rc_osc_clock,
    input  wire logic        keypad_pin_pending,
    output logic             keypad_ack_pulse,
    output logic             keypad_vector_request,
    output logic             wake_latch_out,
    output logic             irq
);

    // -------------------------------------------------------------
    // Bus slave
    // -------------------------------------------------------------
    logic        pready_q;
    logic [31:0] prdata_q;
    logic        pslverr_q;
    logic        access;
    logic        wr_en;
    logic        mapped;
    logic [31:0] rd_mux;

    logic       wake_latch_q;
    logic       flag_q;
    logic       mask_q;
    logic       mode_q;
    logic       wake_ie_q;
    logic [5:0] pin_en_q;
    logic       rate_q;
    logic [1:0] evt_status_q;
    logic [1:0] evt_mask_q;
    logic       ack_q;

    assign access = psel & penable & ~pready_q;
    assign wr_en  = psel & penable & pready_q & pwrite;

    always_comb begin
        rd_mux = wake_pkg::DATA_ZERO;
        mapped = 1'b1;
        unique case (paddr)
            wake_pkg::ADDR_PORT_A:
                rd_mux[wake_pkg::BIT_WAKE_LATCH] = wake_latch_q;
            wake_pkg::ADDR_KEYPAD_SC: begin
                rd_mux[wake_pkg::BIT_PENDING_FLAG] = flag_q;
                rd_mux[wake_pkg::BIT_IRQ_MASK]     = mask_q;
                rd_mux[wake_pkg::BIT_TRIGGER_MODE] = mode_q;
            end
            wake_pkg::ADDR_KEYPAD_IE: begin
                rd_mux[wake_pkg::BIT_WAKE_IRQ_EN] = wake_ie_q;
                rd_mux[wake_pkg::KEYPAD_PIN_BITS-1:0] = pin_en_q;
            end
            wake_pkg::ADDR_CONFIG_ONE:
                rd_mux[wake_pkg::BIT_RATE_SELECT] = rate_q;
            wake_pkg::ADDR_IRQ_STATUS:
                rd_mux[wake_pkg::EVT_BITS-1:0] = evt_status_q;
            wake_pkg::ADDR_IRQ_MASK:
                rd_mux[wake_pkg::EVT_BITS-1:0] = evt_mask_q;
            default:
                mapped = 1'b0;
        endcase
    end

    // One wait state: answer in the second access cycle
    always_ff @(posedge clk) begin
        if (rst) begin
            pready_q <= 1'b0;
        end else begin
            pready_q <= access;
        end
    end

    // Unmapped offsets are refused with an error response
    always_ff @(posedge clk) begin
        if (rst) begin
            pslverr_q <= 1'b0;
        end else begin
            pslverr_q <= access & ~mapped;
        end
    end

    // Read data holds until the next good read
    always_ff @(posedge clk) begin
        if (rst) begin
            prdata_q <= wake_pkg::DATA_ZERO;
        end else if (access && !pwrite && mapped) begin
            prdata_q <= rd_mux;
        end
    end

    // -------------------------------------------------------------
    // Keypad status/control: mask and trigger mode
    // -------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            mask_q <= 1'b0;
        end else if (wr_en && paddr == wake_pkg::ADDR_KEYPAD_SC) begin
            mask_q <= pwdata[wake_pkg::BIT_IRQ_MASK];
        end
    end

    // Stored for software only; the pin edge logic sits outside
    always_ff @(posedge clk) begin
        if (rst) begin
            mode_q <= 1'b0;
        end else if (wr_en && paddr == wake_pkg::ADDR_KEYPAD_SC) begin
            mode_q <= pwdata[wake_pkg::BIT_TRIGGER_MODE];
        end
    end

    // -------------------------------------------------------------
    // Keypad irq enable: wake enable and pin enables
    // -------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            wake_ie_q <= 1'b0;
        end else if (wr_en && paddr == wake_pkg::ADDR_KEYPAD_IE) begin
            wake_ie_q <= pwdata[wake_pkg::BIT_WAKE_IRQ_EN];
        end
    end

    // Pin enables are kept for readback only
    always_ff @(posedge clk) begin
        if (rst) begin
            pin_en_q <= wake_pkg::PIN_EN_RESET;
        end else if (wr_en && paddr == wake_pkg::ADDR_KEYPAD_IE) begin
            pin_en_q <= pwdata[wake_pkg::KEYPAD_PIN_BITS-1:0];
        end
    end

    // -------------------------------------------------------------
    // Config one: wake period select
    // -------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            rate_q <= 1'b0;
        end else if (wr_en && paddr == wake_pkg::ADDR_CONFIG_ONE) begin
            rate_q <= pwdata[wake_pkg::BIT_RATE_SELECT];
        end
    end

    // -------------------------------------------------------------
    // Interrupt mask
    // -------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            evt_mask_q <= wake_pkg::EVT_RESET;
        end else if (wr_en && paddr == wake_pkg::ADDR_IRQ_MASK) begin
            evt_mask_q <= pwdata[wake_pkg::EVT_BITS-1:0];
        end
    end

    // Acknowledge strobe: write-only, never stored for readback
    logic ack_write;
    assign ack_write = wr_en && (paddr == wake_pkg::ADDR_KEYPAD_SC)
                       && pwdata[wake_pkg::BIT_ACKNOWLEDGE];

    always_ff @(posedge clk) begin
        if (rst) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= ack_write;
        end
    end

    // -------------------------------------------------------------
    // RC oscillator synchroniser
    // -------------------------------------------------------------
    logic rc_s1_q;
    logic rc_s2_q;
    logic rc_s3_q;
    logic rc_level_q;
    logic rc_rise;

    always_ff @(posedge clk) begin
        if (rst) begin
            rc_s1_q <= 1'b0;
            rc_s2_q <= 1'b0;
            rc_s3_q <= 1'b0;
        end else begin
            rc_s1_q <= internal_rc_osc_clock;
            rc_s2_q <= rc_s1_q;
            rc_s3_q <= rc_s2_q;
        end
    end

    // Level moves only once the second and third stages agree
    always_ff @(posedge clk) begin
        if (rst) begin
            rc_level_q <= 1'b0;
        end else if (rc_s2_q == rc_s3_q) begin
            rc_level_q <= rc_s3_q;
        end
    end

    // One pulse per settled rising edge of the oscillator
    assign rc_rise = rc_s2_q & rc_s3_q & ~rc_level_q;

    // -------------------------------------------------------------
    // Wakeup counter
    // -------------------------------------------------------------
    logic [13:0] wake_cnt_q;
    logic [13:0] wake_last;
    logic        wake_run;
    logic        wake_ovf;

    assign wake_last = rate_q ? wake_pkg::WAKE_SHORT_LAST
                              : wake_pkg::WAKE_LONG_LAST;
    assign wake_run  = stop_mode & wake_ie_q;
    assign wake_ovf  = wake_run & rc_rise & (wake_cnt_q >= wake_last);

    logic [13:0] wake_cnt_d;

    // Held at zero outside stop mode, so every entry starts afresh
    always_comb begin
        wake_cnt_d = wake_cnt_q;
        if (!wake_run) begin
            wake_cnt_d = wake_pkg::WAKE_CNT_ZERO;
        end else if (wake_ovf) begin
            wake_cnt_d = wake_pkg::WAKE_CNT_ZERO;
        end else if (rc_rise) begin
            wake_cnt_d = wake_cnt_q + wake_pkg::WAKE_CNT_ONE;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            wake_cnt_q <= wake_pkg::WAKE_CNT_ZERO;
        end else begin
            wake_cnt_q <= wake_cnt_d;
        end
    end

    // -------------------------------------------------------------
    // Wake latch and keypad flag
    // -------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            wake_latch_q <= 1'b0;
        end else if (wake_ovf && wake_ie_q) begin
            wake_latch_q <= 1'b1;
        end else if (ack_write) begin
            wake_latch_q <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            flag_q <= 1'b0;
        end else begin
            flag_q <= keypad_pin_pending | wake_latch_q;
        end
    end

    logic vec_q;

    always_ff @(posedge clk) begin
        if (rst) begin
            vec_q <= 1'b0;
        end else begin
            vec_q <= flag_q & ~mask_q;
        end
    end

    // -------------------------------------------------------------
    // Event status and interrupt
    // -------------------------------------------------------------
    logic [1:0] evt_set;
    logic [1:0] evt_clr;
    logic       irq_q;
    logic       flag_prev_q;

    always_ff @(posedge clk) begin
        if (rst) begin
            flag_prev_q <= 1'b0;
        end else begin
            flag_prev_q <= flag_q;
        end
    end

    always_comb begin
        evt_set = wake_pkg::EVT_RESET;
        evt_set[wake_pkg::BIT_EVT_WAKE]   = wake_ovf & wake_ie_q;
        evt_set[wake_pkg::BIT_EVT_KEYPAD] = flag_q & ~flag_prev_q;
        evt_clr = wake_pkg::EVT_RESET;
        if (wr_en && paddr == wake_pkg::ADDR_IRQ_STATUS) begin
            evt_clr = pwdata[wake_pkg::EVT_BITS-1:0];
        end
    end

    // Each status bit: set wins over a simultaneous clear
    for (genvar g = 0; g < wake_pkg::EVT_BITS; g++) begin
        always_ff @(posedge clk) begin
            if (rst) begin
                evt_status_q[g] <= 1'b0;
            end else if (evt_set[g]) begin
                evt_status_q[g] <= 1'b1;
            end else if (evt_clr[g]) begin
                evt_status_q[g] <= 1'b0;
            end
        end
    end

    // -------------------------------------------------------------
    // Interrupt output
    // -------------------------------------------------------------
    logic irq_d;

    // Uses the next status value so the output stays a plain flop
    assign irq_d = |(((evt_status_q & ~evt_clr) | evt_set) & evt_mask_q);

    always_ff @(posedge clk) begin
        if (rst) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= irq_d;
        end
    end

    assign pready                = pready_q;
    assign prdata                = prdata_q;
    assign pslverr               = pslverr_q;
    assign keypad_ack_pulse      = ack_q;
    assign keypad_vector_request = vec_q;
    assign wake_latch_out        = wake_latch_q;
    assign irq                   = irq_q;

endmodule

// ### verif/wake_chk.sv
`timescale 1ns/1ps
module wake_chk (
    input wire logic        clk,
    input wire logic        rst,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic        pready,
    input wire logic [31:0] prdata,
    input wire logic        pslverr,
    input wire logic        stop_mode,
    input wire logic        keypad_ack_pulse,
    input wire logic        wake_latch_out
);
    // ----------------------------------------
    // Bus and wake latch checks
    // ----------------------------------------
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    wire logic ack_done;
    wire logic rd_done;
    assign ack_done = psel && penable && pready && pwrite && paddr == wake_pkg::ADDR_KEYPAD_SC
                      && pwdata[wake_pkg::BIT_ACKNOWLEDGE];
    assign rd_done = pready && !pwrite && !pslverr;
    sequence acc_s;
        psel && penable && !pready;
    endsequence
    sequence ack_s;
        ack_done ##1 keypad_ack_pulse;
    endsequence
    ready_one_a: assert property (acc_s |=> pready)
        else $error("pready missing after access");
    err_only_a: assert property (pslverr |-> pready)
        else $error("pslverr outside ready");
    unmapped_a: assert property (pready && paddr > wake_pkg::ADDR_IRQ_MASK |-> pslverr)
        else $error("unmapped access not refused");
    ack_pulse_a: assert property (ack_done |-> ack_s)
        else $error("acknowledge pulse missing");
    ack_cause_a: assert property (keypad_ack_pulse |-> $past(ack_done))
        else $error("acknowledge pulse without write");
    latch_hold_a: assert property (wake_latch_out && !ack_done && !$past(ack_done)
        |=> wake_latch_out)
        else $error("wake latch lost without acknowledge");
    latch_stop_a: assert property ($rose(wake_latch_out) |-> $past(stop_mode))
        else $error("wake latch set outside stop mode");
    sc_zero_a: assert property (rd_done && paddr == wake_pkg::ADDR_KEYPAD_SC
        |-> prdata[7:4] == 4'h0 && !prdata[2])
        else $error("keypad status upper bits not zero");
    port_a_ro_a: assert property (rd_done && paddr == wake_pkg::ADDR_PORT_A
        |-> (prdata & 32'hffff_ffbf) == 32'h0)
        else $error("port A read shows extra bits");
    rdata_hold_a: assert property ($changed(prdata) |-> pready && !pwrite)
        else $error("read data changed outside a read");
endmodule
bind auto_wake_unit wake_chk chk_i (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .stop_mode(stop_mode), .keypad_ack_pulse(keypad_ack_pulse),
    .wake_latch_out(wake_latch_out));

// ### verif/kbd_pin_model.sv
`timescale 1ns/1ps
module kbd_pin_model (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic press,
    input  wire logic keypad_ack_pulse,
    output logic      keypad_pin_pending
);
    // ----------------------------------------
    // Pin request held until acknowledged
    // ----------------------------------------
    always_ff @(posedge clk) begin
        if (rst || keypad_ack_pulse) begin
            keypad_pin_pending <= 1'b0;
        end else if (press) begin
            keypad_pin_pending <= 1'b1;
        end
    end
endmodule

// ### verif/test_stop_mode_auto_wakeup.sv
`timescale 1ns/1ps
module test_stop_mode_auto_wakeup;
    localparam logic [7:0] A_PA = wake_pkg::ADDR_PORT_A, A_SC = wake_pkg::ADDR_KEYPAD_SC;
    localparam logic [7:0] A_IE = wake_pkg::ADDR_KEYPAD_IE, A_CF = wake_pkg::ADDR_CONFIG_ONE;
    localparam logic [7:0] A_ST = wake_pkg::ADDR_IRQ_STATUS, A_MK = wake_pkg::ADDR_IRQ_MASK;
    logic        clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic        stop_mode = 1'b0, rc = 1'b0, press = 1'b0, err_q;
    logic        pready, pslverr, pin, ack, vec, latch, irq;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [7:0]  rw [5] = '{A_IE, A_SC, A_PA, A_CF, A_MK};
    int          err_total = 0, check_count = 0, seed = 32'h21db5799, seen;
    int          ie_m = 0, sc_m = 0, cfg_m = 0, st_m = 0, mk_m = 0, lat_m = 0, pin_m = 0;
    always #12.5 clk = ~clk;
    auto_wake_unit uut (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .stop_mode(stop_mode), .internal_rc_osc_clock(rc), .keypad_pin_pending(pin),
        .keypad_ack_pulse(ack), .keypad_vector_request(vec), .wake_latch_out(latch), .irq(irq));
    kbd_pin_model far (.clk(clk), .rst(rst), .press(press), .keypad_ack_pulse(ack),
        .keypad_pin_pending(pin));
    // ----------------------------------------
    // Bus tasks and reference model
    // ----------------------------------------
    task automatic finish_test;
        $display("checks %0d errors %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            err_total++;
            $display("BAD %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            err_total++;
            finish_test();
        end
        rd = prdata;
        err_q = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    function automatic logic [31:0] expv(input logic [7:0] a);
        case (a)
            A_PA:    return 32'(lat_m << 6);
            A_SC:    return 32'(((pin_m | lat_m) << 3) | sc_m);
            A_IE:    return 32'(ie_m);
            A_CF:    return 32'(cfg_m);
            A_ST:    return 32'(st_m);
            default: return 32'(mk_m);
        endcase
    endfunction
    task automatic rdc(input logic [7:0] a);
        apb(1'b0, a, 32'h0);
        chk("read", expv(a), rd);
    endtask
    task automatic wrm(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
        case (a)
            A_IE:    ie_m = d & 32'h7f;
            A_SC:    sc_m = d & 32'h3;
            A_CF:    cfg_m = d & 32'h1;
            A_ST:    st_m = st_m & ~d & 3;
            A_MK:    mk_m = d & 32'h3;
            default: ;
        endcase
        if (a == A_SC && d[2]) begin
            lat_m = 0;
            pin_m = 0;
            repeat (4) @(posedge clk);
        end
    endtask
    task automatic flags;
        repeat (3) @(posedge clk);
        chk("latch", lat_m, latch);
        chk("vector", (pin_m | lat_m) && !sc_m[1], vec);
        chk("irq", (st_m & mk_m) != 0, irq);
    endtask
    task automatic run(input int c, input int e, input int s, input int n, input int exp);
        wrm(A_CF, c);
        wrm(A_IE, e);
        stop_mode <= s[0];
        seen = 0;
        for (int k = 1; k <= n; k++) begin
            repeat (5) @(posedge clk);
            rc <= 1'b1;
            repeat (5) @(posedge clk);
            rc <= 1'b0;
            if (latch === 1'b1 && seen == 0) seen = k;
        end
        stop_mode <= 1'b0;
        chk("wake_edge", exp, seen);
        if (exp != 0) begin
            st_m = st_m | (pin_m != 0 ? 1 : 3);
            lat_m = 1;
        end
    endtask
    initial begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        for (int a = 0; a <= 20; a += 4) rdc(8'(a));
        apb(1'b1, 8'h1c, 32'hffff_ffff);
        chk("slverr", 1, err_q);
        for (int i = 0; i < 4; i++) begin
            for (int j = 0; j < 5; j++) begin
                wrm(rw[j], $random(seed));
                rdc(rw[j]);
            end
        end
        wrm(A_MK, 3);
        wrm(A_SC, 0);
        run(1, 32'h40, 0, 60, 0);
        run(1, 32'h00, 1, 600, 0);
        run(0, 32'h40, 1, 600, 0);
        run(1, 32'h40, 1, 300, 0);
        run(1, 32'h40, 1, 520, 512);
        flags();
        rdc(A_PA);
        rdc(A_SC);
        rdc(A_ST);
        wrm(A_SC, 2);
        flags();
        wrm(A_MK, 0);
        flags();
        wrm(A_MK, 3);
        wrm(A_SC, 0);
        wrm(A_IE, 0);
        rdc(A_PA);
        wrm(A_SC, 4);
        flags();
        wrm(A_ST, 1);
        rdc(A_ST);
        press <= 1'b1;
        @(posedge clk);
        press <= 1'b0;
        pin_m = 1;
        st_m = st_m | 2;
        flags();
        rdc(A_SC);
        wrm(A_SC, 4);
        flags();
        wrm(A_ST, 3);
        flags();
        run(1, 32'h40, 1, 520, 512);
        rst <= 1'b1;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        {ie_m, sc_m, cfg_m, st_m, mk_m, lat_m, pin_m} = '0;
        flags();
        rdc(A_IE);
        rdc(A_SC);
        finish_test();
    end
endmodule
